// *** src/sar_converter_control.sv ***
// Converter control top: AHB-Lite registers, start and trigger logic, result lock
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "sar_map.svh"
module sar_converter_control
  import sar_pkg::*;
#(
  parameter int AW = 8,
  parameter int NTRIG = 8,
  parameter int PSW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NTRIG-1:0] trigger_in,
  input wire logic comparator_in,
  output logic analog_enable,
  output logic [2:0] ref_sel_out,
  output logic [3:0] channel_sel_out,
  output logic gain_bypass,
  output logic temp_sensor_sel,
  output logic sample_hold,
  output result_t dac_code
);
  // Software-visible state, then the internal read lock, first-conversion and trigger edge state
  logic converter_enable_reg;
  logic start_busy_reg;
  logic auto_trigger_enable_reg;
  logic conversion_done_flag_reg;
  logic [2:0] prescale_reg;
  logic [2:0] trigger_source_select_reg;
  logic [2:0] ref_select_reg;
  logic [3:0] channel_gain_select_reg;
  logic left_justify_reg;
  result_t result_reg;
  logic lock_reg;
  logic first_reg;
  logic trig_prev_reg;

  // Bus pipeline
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [AW-1:0] addr_reg;

  logic seq_busy;
  logic seq_done;
  logic seq_tick;
  result_t seq_result;
  logic addr_phase;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_input_sel;
  logic rd_lo;
  logic rd_hi;
  logic sw_start;
  logic trig_sel;
  logic trig_edge;
  logic trig_start;
  logic free_run;
  logic restart_free;

  // Channel codes below four are the single-ended pins
  function automatic logic is_single(input logic [3:0] ch);
    is_single = (ch[3:2] == `CH_SINGLE_TOP);
  endfunction

  function automatic logic [7:0] read_mux(input logic [AW-1:0] a);
    logic [7:0] v;
    v = `RST_BYTE;
    unique case (a)
      `OFS_CTRL_A: begin
        v[`CA_ENABLE] = converter_enable_reg;
        v[`CA_START] = start_busy_reg;
        v[`CA_AUTO] = auto_trigger_enable_reg;
        v[`CA_DONE] = conversion_done_flag_reg;
        v[`CA_PS_HI:`CA_PS_LO] = prescale_reg;
      end
      `OFS_CTRL_B: v[`CB_TS_HI:`CB_TS_LO] = trigger_source_select_reg;
      `OFS_INPUT_SEL: begin
        v[`IS_REF_HI:`IS_REF_LO] = ref_select_reg[1:0];
        v[`IS_LEFT] = left_justify_reg;
        v[`IS_REF_TOP] = ref_select_reg[2];
        v[`IS_CH_HI:`IS_CH_LO] = channel_gain_select_reg;
      end
      `OFS_RESULT_LO: begin
        v = left_justify_reg ? {result_reg[1:0], 6'h00} : result_reg[7:0];
      end
      `OFS_RESULT_HI: begin
        v = left_justify_reg ? result_reg[9:2] : {6'h00, result_reg[9:8]};
      end
      default: v = `RST_BYTE;
    endcase
    return v;
  endfunction

  assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  assign wr_ctrl_a = wr_pend_reg && (addr_reg == `OFS_CTRL_A);
  assign wr_ctrl_b = wr_pend_reg && (addr_reg == `OFS_CTRL_B);
  assign wr_input_sel = wr_pend_reg && (addr_reg == `OFS_INPUT_SEL);
  assign rd_lo = rd_pend_reg && (addr_reg == `OFS_RESULT_LO);
  assign rd_hi = rd_pend_reg && (addr_reg == `OFS_RESULT_HI);

  assign sw_start = wr_ctrl_a && hwdata[`CA_START] && converter_enable_reg;
  assign free_run = auto_trigger_enable_reg && (trigger_source_select_reg == `TS_FREE_RUN);
  assign trig_sel = trigger_in[trigger_source_select_reg];
  assign trig_edge = trig_sel && !trig_prev_reg;
  // Edges while busy are dropped, not queued
  assign trig_start = auto_trigger_enable_reg && !free_run && trig_edge
    && converter_enable_reg && !start_busy_reg;
  assign restart_free = free_run && seq_done;

  // Bus slave: writes land in the data phase, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_reg <= haddr;
      end
      hreadyout <= !(addr_phase && !hwrite);
      if (rd_pend_reg) begin
        hrdata <= {24'h000000, read_mux(addr_reg)};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_enable_reg <= 1'b0;
      auto_trigger_enable_reg <= 1'b0;
      prescale_reg <= `RST_PS;
      trigger_source_select_reg <= `RST_TS;
      ref_select_reg <= `RST_REF;
      channel_gain_select_reg <= `RST_CH;
      left_justify_reg <= 1'b0;
    end else begin
      if (wr_ctrl_a) begin
        converter_enable_reg <= hwdata[`CA_ENABLE];
        auto_trigger_enable_reg <= hwdata[`CA_AUTO];
        prescale_reg <= hwdata[`CA_PS_HI:`CA_PS_LO];
      end
      if (wr_ctrl_b) begin
        trigger_source_select_reg <= hwdata[`CB_TS_HI:`CB_TS_LO];
      end
      if (wr_input_sel) begin
        ref_select_reg <= {hwdata[`IS_REF_TOP], hwdata[`IS_REF_HI:`IS_REF_LO]};
        left_justify_reg <= hwdata[`IS_LEFT];
        channel_gain_select_reg <= hwdata[`IS_CH_HI:`IS_CH_LO];
      end
    end
  end

  // Start/busy bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_busy_reg <= 1'b0;
    end else if (!converter_enable_reg) begin
      start_busy_reg <= 1'b0;
    end else if (sw_start || trig_start) begin
      start_busy_reg <= 1'b1;
    end else if (seq_done && !restart_free) begin
      start_busy_reg <= 1'b0;
    end
  end

  // Completion flag: set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag_reg <= 1'b0;
    end else if (seq_done) begin
      conversion_done_flag_reg <= 1'b1;
    end else if (wr_ctrl_a && hwdata[`CA_DONE]) begin
      conversion_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sel;
    end
  end

  // Longer first conversion after every enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_reg <= 1'b1;
    end else if (!converter_enable_reg) begin
      first_reg <= 1'b1;
    end else if (seq_done) begin
      first_reg <= 1'b0;
    end
  end

  // Result store and read lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= `RST_RESULT;
    end else if (seq_done && !lock_reg) begin
      result_reg <= seq_result;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_reg <= 1'b0;
    end else if (rd_lo) begin
      lock_reg <= 1'b1;
    end else if (rd_hi) begin
      lock_reg <= 1'b0;
    end
  end

  // Analog path selection, frozen during a conversion and while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_enable <= 1'b0;
      ref_sel_out <= `RST_REF;
      channel_sel_out <= `RST_CH;
      gain_bypass <= 1'b1;
      temp_sensor_sel <= 1'b0;
    end else begin
      analog_enable <= converter_enable_reg;
      if (converter_enable_reg && !seq_busy) begin
        ref_sel_out <= ref_select_reg;
        channel_sel_out <= channel_gain_select_reg;
        gain_bypass <= is_single(channel_gain_select_reg)
          || (channel_gain_select_reg == `CH_TEMP);
        temp_sensor_sel <= (channel_gain_select_reg == `CH_TEMP);
      end
    end
  end

  sar_prescaler #(
    .CW(PSW)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(converter_enable_reg),
    .restart(trig_start),
    .ratio_sel(prescale_reg),
    .tick(seq_tick)
  );

  sar_sequencer u_sequencer (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(converter_enable_reg),
    .tick(seq_tick),
    .go(start_busy_reg),
    .first(first_reg),
    .comparator_in(comparator_in),
    .busy(seq_busy),
    .done(seq_done),
    .sample_hold(sample_hold),
    .trial(dac_code),
    .result(seq_result)
  );

  // A completion that lands while the low byte read holds the lock
  sequence s_locked_done;
    lock_reg && seq_done;
  endsequence

  property p_sw_start;
    @(posedge hclk) disable iff (!hresetn) sw_start |=> start_busy_reg;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("start write did not set busy");

  property p_single_clear;
    @(posedge hclk) disable iff (!hresetn)
      (seq_done && !free_run && !sw_start && !trig_start) |=> !start_busy_reg;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("busy not cleared");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn) seq_done |=> conversion_done_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");

  property p_lock_hold;
    @(posedge hclk) disable iff (!hresetn) s_locked_done |=> $stable(result_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");

  property p_update;
    @(posedge hclk) disable iff (!hresetn)
      (seq_done && !lock_reg) |=> (result_reg == $past(seq_result));
  endproperty
  a_update: assert property (p_update) else $error("result not written");

  property p_unlock;
    @(posedge hclk) disable iff (!hresetn) (rd_hi && !rd_lo) |=> !lock_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read kept lock");

  property p_sel_frozen;
    @(posedge hclk) disable iff (!hresetn)
      (seq_busy && $past(seq_busy)) |-> $stable(channel_sel_out);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen) else $error("channel changed mid conversion");

  property p_disabled;
    @(posedge hclk) disable iff (!hresetn)
      (!converter_enable_reg && $past(!converter_enable_reg)) |=> $stable(channel_sel_out);
  endproperty
  a_disabled: assert property (p_disabled) else $error("selection applied while disabled");

  property p_free_run;
    @(posedge hclk) disable iff (!hresetn)
      (restart_free && converter_enable_reg) |=> start_busy_reg;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run dropped busy");

  property p_no_tick_off;
    @(posedge hclk) disable iff (!hresetn) !converter_enable_reg |=> !seq_tick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off) else $error("prescaler ran disabled");

  property p_busy_read;
    @(posedge hclk) disable iff (!hresetn) seq_busy |-> start_busy_reg;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit low in conversion");
endmodule // sar_converter_control

// *** src/sar_map.svh ***
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_INPUT_SEL 8'h08
`define OFS_RESULT_LO 8'h0c
`define OFS_RESULT_HI 8'h10

`define CA_ENABLE 7
`define CA_START 6
`define CA_AUTO 5
`define CA_DONE 4
`define CA_PS_HI 2
`define CA_PS_LO 0

`define IS_REF_HI 7
`define IS_REF_LO 6
`define IS_LEFT 5
`define IS_REF_TOP 4
`define IS_CH_HI 3
`define IS_CH_LO 0

`define CB_TS_HI 2
`define CB_TS_LO 0

`define RST_BYTE 8'h00
`define RST_REF 3'h0
`define RST_CH 4'h0
`define RST_TS 3'h0
`define RST_PS 3'h0
`define RST_RESULT 10'h000

`define TS_FREE_RUN 3'h0
`define CH_TEMP 4'hf
`define CH_SINGLE_TOP 2'h0
`define HTRANS_NONSEQ_BIT 1

`define LEN_NORMAL 5'd13
`define LEN_FIRST 5'd25
`define SH_NORMAL 5'd2
`define SH_FIRST 5'd14
`define TRIAL_INIT 10'h200
`define MSB_IDX 4'd9

`endif

// *** src/sar_pkg.sv ***
// Types shared by the converter control modules
package sar_pkg;
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} seq_state_t;
  typedef logic [9:0] result_t;
endpackage

// *** src/sar_prescaler.sv ***
// Converter clock prescaler producing one tick per converter clock period
`timescale 1ns/1ns
`include "sar_map.svh"
module sar_prescaler #(
  parameter int CW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic [2:0] ratio_sel,
  output logic tick
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] mask;

  // Divide by two to the power of ratio_sel plus one
  assign mask = {CW{1'b1}} >> (3'd7 - ratio_sel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else if (!enable || restart) begin
      count_reg <= '0;
    end else if (count_reg == mask) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= enable && !restart && (count_reg == mask);
    end
  end
endmodule // sar_prescaler

// *** src/sar_sequencer.sv ***
// Successive approximation sequencer: sample phase, bit trials and completion
`timescale 1ns/1ns
`include "sar_map.svh"
module sar_sequencer
  import sar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic go,
  input wire logic first,
  input wire logic comparator_in,
  output logic busy,
  output logic done,
  output logic sample_hold,
  output result_t trial,
  output result_t result
);
  seq_state_t state_reg;
  logic [4:0] cycle_reg;
  logic [3:0] idx_reg;
  logic [4:0] len;
  logic [4:0] sh_end;

  assign len = first ? `LEN_FIRST : `LEN_NORMAL;
  assign sh_end = first ? `SH_FIRST : `SH_NORMAL;
  assign busy = (state_reg == SEQ_CONV);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SEQ_IDLE;
      cycle_reg <= '0;
      idx_reg <= `MSB_IDX;
      trial <= `RST_RESULT;
      result <= `RST_RESULT;
      done <= 1'b0;
      sample_hold <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        state_reg <= SEQ_IDLE;
        sample_hold <= 1'b0;
      end else if (tick) begin
        unique case (state_reg)
          SEQ_IDLE: begin
            if (go) begin
              state_reg <= SEQ_CONV;
              cycle_reg <= 5'd1;
              idx_reg <= `MSB_IDX;
              trial <= `TRIAL_INIT;
              sample_hold <= 1'b1;
            end
          end
          SEQ_CONV: begin
            cycle_reg <= cycle_reg + 5'd1;
            if (cycle_reg == sh_end) begin
              sample_hold <= 1'b0;
            end
            if (cycle_reg > sh_end && cycle_reg < len) begin
              // MSB first, one comparator decision per converter clock
              trial[idx_reg] <= comparator_in;
              if (idx_reg != 4'd0) begin
                trial[idx_reg - 4'd1] <= 1'b1;
              end
              idx_reg <= idx_reg - 4'd1;
            end
            if (cycle_reg == len) begin
              result <= trial;
              done <= 1'b1;
              state_reg <= SEQ_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // sar_sequencer

// *** tb/sar_front_model.sv ***
// Comparator front-end model: sample and hold of the selected channel level and its comparator
`timescale 1ns/1ns
module sar_front_model
  import sar_pkg::*;
(
  input wire logic hclk,
  input wire logic analog_enable,
  input wire logic [3:0] channel_sel_out,
  input wire logic sample_hold,
  input wire result_t dac_code,
  input wire logic [9:0] level [16],
  output logic comparator_in
);
  result_t held;
  logic flip;
  initial flip = 1'b0;
  initial held = '0;
  always @(posedge hclk) begin
    flip <= ~flip;
    if (sample_hold === 1'b1) begin
      held <= level[channel_sel_out];
    end
  end
  // A powered-down front end gives a decision that changes every cycle
  assign comparator_in = (analog_enable === 1'b1) ? (held >= dac_code) : flip;
endmodule // sar_front_model

// *** tb/tb_top.sv ***
// Self-checking testbench of the converter control with a front-end model
`timescale 1ns/1ns
module tb_top;
  import sar_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sh_d;
  logic comparator_in, analog_enable, gain_bypass, temp_sensor_sel, sample_hold;
  logic [7:0] haddr, trigger_in;
  logic [1:0] htrans;
  logic [2:0] hsize, ref_sel_out, ps;
  logic [31:0] hwdata, hrdata, q;
  logic [3:0] channel_sel_out;
  result_t dac_code;
  logic [9:0] lvl [16];
  int mismatches, cmp_count, conv_count, sh_cnt, sh_last, cyc, rise_t, gap_last, div, c0, n;
  int exp_q [$];

  assign hready = hreadyout;

  sar_converter_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
    .comparator_in(comparator_in), .analog_enable(analog_enable), .ref_sel_out(ref_sel_out),
    .channel_sel_out(channel_sel_out), .gain_bypass(gain_bypass),
    .temp_sensor_sel(temp_sensor_sel), .sample_hold(sample_hold), .dac_code(dac_code));

  sar_front_model front (.hclk(hclk), .analog_enable(analog_enable),
    .channel_sel_out(channel_sel_out), .sample_hold(sample_hold), .dac_code(dac_code),
    .level(lvl), .comparator_in(comparator_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Counts conversions and measures sample width and start-to-start spacing
  always @(posedge hclk) begin
    cyc++;
    sh_d <= sample_hold;
    if (sample_hold === 1'b1) sh_cnt++;
    if (sample_hold === 1'b1 && sh_d !== 1'b1) begin
      conv_count++;
      gap_last = cyc - rise_t;
      rise_t = cyc;
    end
    if (sample_hold !== 1'b1 && sh_d === 1'b1) begin
      sh_last = sh_cnt;
      sh_cnt = 0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask

  task automatic wait_idle;
    logic [31:0] s;
    int k;
    k = 0;
    do begin
      rd(8'h00, s);
      k++;
    end while (s[6] === 1'b1 && k < 300);
    check("start bit clears", s[6], 1'b0);
  endtask

  task automatic res(input int v, input bit left);
    logic [9:0] r;
    logic [31:0] lo, hi;
    r = v[9:0];
    rd(8'h0c, lo);
    rd(8'h10, hi);
    check("result low", lo, left ? {24'h0, r[1:0], 6'h0} : {24'h0, r[7:0]});
    check("result high", hi, left ? {24'h0, r[9:2]} : {30'h0, r[9:8]});
    check("final trial code", dac_code, r);
  endtask

  task automatic conv(input logic [3:0] ch, input bit left);
    logic [31:0] s;
    lvl[ch] = 10'($urandom_range(1023, 0));
    exp_q.push_back(int'(lvl[ch]));
    wr(8'h08, {24'h0, 2'b00, left, 1'b0, ch});
    wr(8'h00, {24'h0, 5'b11010, ps});
    rd(8'h00, s);
    check("start bit while converting", s[6], 1'b1);
    wait_idle();
    rd(8'h00, s);
    check("done flag", s[4], 1'b1);
    res(exp_q.pop_front(), left);
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    trigger_in = 8'h00;
    foreach (lvl[i]) lvl[i] = 10'h000;
    void'($urandom(32'h688d));
    ps = 3'($urandom_range(1, 0));
    div = 2 << ps;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), q);
      check("reset register", q, 32'h0);
      check("bus response", hresp, 1'b0);
    end
    wr(8'h14, 32'hff);
    rd(8'h14, q);
    check("unmapped", q, 32'h0);
    wr(8'h08, 32'h43);
    repeat (2) @(posedge hclk);
    check("channel while disabled", channel_sel_out, 4'h0);
    check("reference while disabled", ref_sel_out, 3'h0);
    check("power while disabled", analog_enable, 1'b0);
    wr(8'h00, {24'h0, 5'b10000, ps});
    repeat (2) @(posedge hclk);
    check("power on", analog_enable, 1'b1);
    check("channel applied", channel_sel_out, 4'h3);
    check("reference applied", ref_sel_out, 3'h1);
    conv(4'h3, 1'b0);
    check("first sample width", sh_last >= 13 * div && sh_last <= 15 * div, 1'b1);
    conv(4'h2, 1'b1);
    check("normal sample width", sh_last >= div && sh_last <= 3 * div, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wr(8'h08, {24'h0, i[1:0], 1'b0, i[2], i[3:0]});
      repeat (2) @(posedge hclk);
      check("channel code", channel_sel_out, i[3:0]);
      check("reference code", ref_sel_out, i[2:0]);
      check("gain bypass", gain_bypass, i < 4 || i == 15);
      check("temperature", temp_sensor_sel, i == 15);
    end
    conv(4'h1, 1'b0);
    n = int'(lvl[1]);
    rd(8'h0c, q);
    lvl[1] = ~lvl[1];
    wr(8'h00, {24'h0, 5'b11010, ps});
    wait_idle();
    rd(8'h00, q);
    check("flag on discarded result", q[4], 1'b1);
    rd(8'h10, q);
    check("locked high", q, {30'h0, n[9:8]});
    rd(8'h0c, q);
    check("locked low", q, {24'h0, n[7:0]});
    rd(8'h10, q);
    conv(4'h1, 1'b0);
    lvl[0] = 10'($urandom_range(1023, 0));
    wr(8'h08, 32'h0);
    wr(8'h00, {24'h0, 5'b11010, ps});
    // Let the conversion take its first converter clock before the new channel
    repeat (2 * div) @(posedge hclk);
    wr(8'h08, 32'h2);
    repeat (2) @(posedge hclk);
    check("channel held in conversion", channel_sel_out, 4'h0);
    wait_idle();
    res(int'(lvl[0]), 1'b0);
    repeat (2) @(posedge hclk);
    check("channel after conversion", channel_sel_out, 4'h2);
    for (int t = 1; t < 8; t++) begin
      wr(8'h04, t);
      wr(8'h00, {24'h0, 5'b10110, ps});
      c0 = conv_count;
      trigger_in <= 8'hff ^ (8'h01 << t);
      repeat (20) @(posedge hclk);
      check("other trigger ignored", conv_count, c0);
      trigger_in <= 8'hff;
      repeat (3) @(posedge hclk);
      rd(8'h00, q);
      check("busy after trigger", q[6], 1'b1);
      trigger_in[t] <= 1'b0;
      @(posedge hclk);
      trigger_in[t] <= 1'b1;
      wait_idle();
      repeat (8 * div) @(posedge hclk);
      check("one conversion per edge", conv_count, c0 + 1);
      wr(8'h00, {24'h0, 5'b11110, ps});
      wait_idle();
      check("start with auto on", conv_count, c0 + 2);
      trigger_in <= 8'h00;
    end
    wr(8'h04, 32'h0);
    c0 = conv_count;
    wr(8'h00, {24'h0, 5'b11110, ps});
    n = 0;
    while (conv_count < c0 + 3 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    rd(8'h00, q);
    check("free run busy", q[6], 1'b1);
    check("free run uncleared flag", q[4], 1'b1);
    check("free run count", conv_count >= c0 + 3, 1'b1);
    check("free run period", gap_last >= 13 * div && gap_last <= 14 * div, 1'b1);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge hclk);
    check("power off", analog_enable, 1'b0);
    rd(8'h00, q);
    check("abort clears start", q[6], 1'b0);
    wrap_up();
  end
endmodule // tb_top
